// ===== hdl/dcf_pkg.sv
// Constants, widths and reset values shared by the buffer design
package dcf_pkg;
  localparam int unsigned DATA_W         = 18;
  localparam int unsigned MEM_DEPTH      = 32768;
  localparam int unsigned STAGE_DEPTH    = 16;
  // Partial flag defaults picked by the load strobe during master reset
  localparam int unsigned OFS_DEFAULT_LO = 127;
  localparam int unsigned OFS_DEFAULT_HI = 1023;
  // Reset values
  localparam logic [DATA_W-1:0] OUT_RESET = 18'h00000;
  localparam logic              MODE_RESET_FALL_THROUGH_MODE   = 1'b0;
  localparam logic              PROG_RESET_SERIAL = 1'b0;
  // First-word latency in fall-through mode, in clock edges
  localparam int unsigned FALL_THROUGH_MODE_LATENCY = 3;
  typedef enum logic {
    DCF_PROG_PARALLEL,
    DCF_PROG_SERIAL
  } dcf_prog_t;
endpackage

// ===== hdl/dcf_link_if.sv
// Valid/ready link between the top module and its staging buffer
`timescale 1ns/1ps
interface dcf_link_if #(
  parameter int unsigned W  = 18,
  parameter int unsigned LW = 5
);
  logic          flush;
  logic          in_valid;
  logic          in_ready;
  logic [W-1:0]  in_data;
  logic          out_valid;
  logic          out_ready;
  logic [W-1:0]  out_data;
  logic [LW-1:0] level;
  modport buffer (
    input  flush, in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, level
  );
  modport user (
    output flush, in_valid, in_data, out_ready,
    input  in_ready, out_valid, out_data, level
  );
endinterface

// ===== hdl/dcf_stage_fifo.sv
// Small synchronous staging buffer with valid/ready on both sides
`timescale 1ns/1ps
module dcf_stage_fifo #(
  parameter int unsigned W     = 18,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  dcf_link_if.buffer lnk
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("dcf_stage_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_reg;
  logic [AW:0]   wp_next;
  logic [AW:0]   rp_reg;
  logic [AW:0]   rp_next;
  logic          push;
  logic          pop;

  always_comb begin
    push     = lnk.in_valid && lnk.in_ready;
    pop      = lnk.out_valid && lnk.out_ready;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    if (lnk.flush) begin
      wp_next = '0;
      rp_next = '0;
    end else begin
      if (push) begin
        wp_next = wp_reg + 1'b1;
      end
      if (pop) begin
        rp_next = rp_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !lnk.flush) begin
      mem[wp_reg[AW-1:0]] <= lnk.in_data;
    end
  end

  assign lnk.level     = wp_reg - rp_reg;
  assign lnk.in_ready  = !((wp_reg[AW] != rp_reg[AW]) &&
                           (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign lnk.out_valid = (wp_reg != rp_reg);
  assign lnk.out_data  = mem[rp_reg[AW-1:0]];
endmodule

// ===== hdl/dcf_top.sv
// Deep 18-bit buffer with resets, replay, status and offset flags
`timescale 1ns/1ps
module dcf_top
  import dcf_pkg::*;
#(
  parameter int unsigned DEPTH = dcf_pkg::MEM_DEPTH,
  parameter int unsigned SDEP  = dcf_pkg::STAGE_DEPTH
) (
  // Clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RSTN,
  // Resets and replay
  input  wire logic                      MASTER_RESET_N,
  input  wire logic                      PARTIAL_RESET_N,
  input  wire logic                      REPLAY_REQUEST_N,
  // Configuration and offset loading
  input  wire logic                      MODE_SELECT_SERIAL_IN,
  input  wire logic                      SERIAL_LOAD_ENABLE_N,
  input  wire logic                      OFFSET_LOAD_STROBE_N,
  // Write side
  input  wire logic                      WRITE_ENABLE_N,
  input  wire logic [dcf_pkg::DATA_W-1:0] WRITE_DATA_BUS,
  // Read side
  input  wire logic                      READ_ENABLE_N,
  input  wire logic                      OUTPUT_ENABLE_N,
  output logic      [dcf_pkg::DATA_W-1:0] READ_DATA_BUS,
  output logic                           READ_DATA_OE,
  // Status flags
  output logic                           FULL_OR_SPACE_FLAG,
  output logic                           EMPTY_OR_VALID_FLAG,
  output logic                           ALMOST_FULL_FLAG_N,
  output logic                           ALMOST_EMPTY_FLAG_N,
  output logic                           HALF_FULL_FLAG_N,
  output logic                           FALL_THROUGH_MODE
);
  import dcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(SDEP) + 1;
  localparam int unsigned CW = AW + 2;
  if (DEPTH < 2048 || (1 << AW) != DEPTH || AW > DATA_W) begin : g_chk
    $error("dcf_top: DEPTH must be a power of two, 2048 to 2**18");
  end

  localparam logic [AW-1:0] OFS_LO   = AW'(OFS_DEFAULT_LO);
  localparam logic [AW-1:0] OFS_HI   = AW'(OFS_DEFAULT_HI);
  localparam logic [CW-1:0] CAP      = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_CAP = CW'(DEPTH / 2);

  logic [DATA_W-1:0] mem [DEPTH];

  dcf_link_if #(.W(DATA_W), .LW(LW)) stg ();

  dcf_stage_fifo #(
    .W     (DATA_W),
    .DEPTH (SDEP)
  ) u_stage (
    .clk   (SYS_CLK),
    .rst_n (RSTN),
    .lnk   (stg)
  );

  ////////////////////////////////////////////////////////////////////////
  // State
  logic              fall_through_mode_reg,    fall_through_mode_next;
  dcf_prog_t         prog_reg,    prog_next;
  logic [AW-1:0]     eofs_reg,    eofs_next;
  logic [AW-1:0]     fofs_reg,    fofs_next;
  logic              osel_reg,    osel_next;
  logic [AW:0]       wp_reg,      wp_next;
  logic [AW:0]       rp_reg,      rp_next;
  logic [DATA_W-1:0] q_reg,       q_next;
  logic              qv_reg,      qv_next;
  logic              oe_reg,      oe_next;
  logic              ff_reg,      ff_next;
  logic              ef_reg,      ef_next;
  logic              paf_reg,     paf_next;
  logic              pae_reg,     pae_next;
  logic              hf_reg,      hf_next;

  logic              any_reset;
  logic              load_sel;
  logic              wr_word;
  logic              rd_req;
  logic              replay;
  logic              mem_avail;
  logic              drain;
  logic              load_q;
  logic [CW-1:0]     cnt_next;
  logic              full_now;
  logic [2*AW-1:0]   ofs_shift;

  // Offset register picked by the shared select toggle
  function automatic logic [DATA_W-1:0] ofs_word(
    input logic          sel,
    input logic [AW-1:0] e,
    input logic [AW-1:0] f
  );
    ofs_word = DATA_W'(sel ? f : e);
  endfunction

  // Pointer gap kept at pointer width, so a wrapped write pointer stays right
  function automatic logic [AW:0] ptr_gap(
    input logic [AW:0] w,
    input logic [AW:0] r
  );
    ptr_gap = w - r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    any_reset = !MASTER_RESET_N || !PARTIAL_RESET_N;
    load_sel  = !OFFSET_LOAD_STROBE_N;
    replay    = !REPLAY_REQUEST_N;
    rd_req    = !READ_ENABLE_N && !load_sel;
    full_now  = 1'b0;
    fall_through_mode_next = fall_through_mode_reg;
    prog_next = prog_reg;
    eofs_next = eofs_reg;
    fofs_next = fofs_reg;
    osel_next = osel_reg;
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    q_next    = q_reg;
    qv_next   = qv_reg;
    oe_next   = !OUTPUT_ENABLE_N;
    ofs_shift = {fofs_reg, eofs_reg};
    mem_avail = (wp_reg != rp_reg);
    drain     = stg.out_valid && (wp_reg - rp_reg) != CAP[AW:0];
    load_q    = 1'b0;

    // Total held words, staging included
    cnt_next = CW'(ptr_gap(wp_reg, rp_reg)) + CW'(stg.level);
    full_now = (cnt_next >= CAP);
    wr_word  = !WRITE_ENABLE_N && !load_sel && stg.in_ready &&
               !full_now;

    if (!MASTER_RESET_N) begin
      fall_through_mode_next = MODE_SELECT_SERIAL_IN;
      // Low strobe: 127 parallel, high strobe: 1,023 serial
      prog_next = OFFSET_LOAD_STROBE_N ? DCF_PROG_SERIAL
                                       : DCF_PROG_PARALLEL;
      eofs_next = OFFSET_LOAD_STROBE_N ? OFS_HI : OFS_LO;
      fofs_next = OFFSET_LOAD_STROBE_N ? OFS_HI : OFS_LO;
      osel_next = 1'b0;
    end
    if (any_reset) begin
      wp_next = '0;
      rp_next = '0;
      q_next  = OUT_RESET;
      qv_next = 1'b0;
      if (!PARTIAL_RESET_N && MASTER_RESET_N) begin
        osel_next = 1'b0;
      end
    end else begin
      // Offset loading, parallel then serial
      if (!WRITE_ENABLE_N && load_sel &&
          prog_reg == DCF_PROG_PARALLEL) begin
        if (osel_reg) begin
          fofs_next = WRITE_DATA_BUS[AW-1:0];
        end else begin
          eofs_next = WRITE_DATA_BUS[AW-1:0];
        end
        osel_next = !osel_reg;
      end else if (!SERIAL_LOAD_ENABLE_N && load_sel &&
                   prog_reg == DCF_PROG_SERIAL) begin
        ofs_shift = {ofs_shift[2*AW-2:0], MODE_SELECT_SERIAL_IN};
        {fofs_next, eofs_next} = ofs_shift;
      end
      if (drain) begin
        wp_next = wp_reg + 1'b1;
      end
      // Replay only rewinds reading; write side is left alone
      if (replay) begin
        rp_next = '0;
        qv_next = 1'b0;
      end else if (!READ_ENABLE_N && load_sel) begin
        q_next    = ofs_word(osel_reg, eofs_reg, fofs_reg);
        osel_next = !osel_reg;
      end else begin
        if (fall_through_mode_reg) begin
          // Prefetch so the head word falls through unrequested
          load_q = mem_avail && (!qv_reg || rd_req);
          if (rd_req && qv_reg && !mem_avail) begin
            qv_next = 1'b0;
          end
        end else begin
          load_q = mem_avail && rd_req;
        end
        if (load_q) begin
          q_next  = mem[rp_reg[AW-1:0]];
          qv_next = 1'b1;
          rp_next = rp_reg + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags from the updated pointers
  always_comb begin
    logic [CW-1:0] held;
    logic [CW-1:0] stg_after;
    logic          full_after;
    logic          empty_after;
    held        = '0;
    full_after  = 1'b0;
    empty_after = 1'b0;
    stg_after   = CW'(stg.level);
    if (wr_word && !any_reset) begin
      stg_after = stg_after + CW'(1);
    end
    if (drain && !any_reset) begin
      stg_after = stg_after - CW'(1);
    end
    if (any_reset) begin
      stg_after = '0;
    end
    held        = CW'(ptr_gap(wp_next, rp_next)) + stg_after;
    full_after  = (held >= CAP);
    empty_after = (wp_next == rp_next);
    if (fall_through_mode_next) begin
      ff_next = full_after;
      ef_next = !qv_next;
    end else begin
      ff_next = !full_after;
      ef_next = !empty_after && !(replay && !any_reset);
    end
    paf_next = !(held > CAP - CW'(fofs_next));
    pae_next = !(held < CW'(eofs_next));
    hf_next  = !(held > HALF_CAP);
  end

  ////////////////////////////////////////////////////////////////////////
  // Staging buffer hookup; its ready stalls the write side
  assign stg.flush     = any_reset;
  assign stg.in_valid  = wr_word;
  assign stg.in_data   = WRITE_DATA_BUS;
  assign stg.out_ready = drain;

  always_ff @(posedge SYS_CLK) begin
    if (drain && !any_reset) begin
      mem[wp_reg[AW-1:0]] <= stg.out_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      fall_through_mode_reg <= MODE_RESET_FALL_THROUGH_MODE;
      prog_reg <= dcf_prog_t'(PROG_RESET_SERIAL);
      eofs_reg <= OFS_LO;
      fofs_reg <= OFS_LO;
      osel_reg <= 1'b0;
      wp_reg   <= '0;
      rp_reg   <= '0;
      q_reg    <= OUT_RESET;
      qv_reg   <= 1'b0;
      oe_reg   <= 1'b0;
      ff_reg   <= 1'b1;
      ef_reg   <= 1'b0;
      paf_reg  <= 1'b1;
      pae_reg  <= 1'b0;
      hf_reg   <= 1'b1;
    end else begin
      fall_through_mode_reg <= fall_through_mode_next;
      prog_reg <= prog_next;
      eofs_reg <= eofs_next;
      fofs_reg <= fofs_next;
      osel_reg <= osel_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      q_reg    <= q_next;
      qv_reg   <= qv_next;
      oe_reg   <= oe_next;
      ff_reg   <= ff_next;
      ef_reg   <= ef_next;
      paf_reg  <= paf_next;
      pae_reg  <= pae_next;
      hf_reg   <= hf_next;
    end
  end

  assign READ_DATA_BUS       = q_reg;
  assign READ_DATA_OE        = oe_reg;
  assign FULL_OR_SPACE_FLAG  = ff_reg;
  assign EMPTY_OR_VALID_FLAG = ef_reg;
  assign ALMOST_FULL_FLAG_N  = paf_reg;
  assign ALMOST_EMPTY_FLAG_N = pae_reg;
  assign HALF_FULL_FLAG_N    = hf_reg;
  assign FALL_THROUGH_MODE   = fall_through_mode_reg;
endmodule

// ===== tb/dcf_top_asserts.sv
// Port-level assertions for the deep buffer top
`timescale 1ns/1ps
module dcf_top_asserts (
  // Clock, resets and replay
  input wire logic                       SYS_CLK,
  input wire logic                       RSTN,
  input wire logic                       MASTER_RESET_N,
  input wire logic                       PARTIAL_RESET_N,
  input wire logic                       REPLAY_REQUEST_N,
  // Controls
  input wire logic                       MODE_SELECT_SERIAL_IN,
  input wire logic                       OFFSET_LOAD_STROBE_N,
  input wire logic                       WRITE_ENABLE_N,
  input wire logic                       READ_ENABLE_N,
  input wire logic                       OUTPUT_ENABLE_N,
  // Outputs
  input wire logic [dcf_pkg::DATA_W-1:0] READ_DATA_BUS,
  input wire logic                       READ_DATA_OE,
  input wire logic                       FULL_OR_SPACE_FLAG,
  input wire logic                       EMPTY_OR_VALID_FLAG,
  input wire logic                       ALMOST_FULL_FLAG_N,
  input wire logic                       ALMOST_EMPTY_FLAG_N,
  input wire logic                       HALF_FULL_FLAG_N,
  input wire logic                       FALL_THROUGH_MODE
);
  import dcf_pkg::*;
  wire logic run = MASTER_RESET_N && PARTIAL_RESET_N;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////////////////////
  // Lone write into an empty fall-through buffer
  sequence s_ft_write;
    run && FALL_THROUGH_MODE && EMPTY_OR_VALID_FLAG && !WRITE_ENABLE_N &&
      OFFSET_LOAD_STROBE_N && READ_ENABLE_N && REPLAY_REQUEST_N;
  endsequence
  sequence s_quiet2;
    (run && READ_ENABLE_N && REPLAY_REQUEST_N)[*2];
  endsequence
  chk_mrst_clear:
    assert property (!MASTER_RESET_N |=> READ_DATA_BUS == OUT_RESET)
    else $error("output not cleared");
  chk_mode_latch:
    assert property (!MASTER_RESET_N |=>
      FALL_THROUGH_MODE == $past(MODE_SELECT_SERIAL_IN))
    else $error("mode not latched");
  chk_prst_keep:
    assert property (MASTER_RESET_N && !PARTIAL_RESET_N |=>
      $stable(FALL_THROUGH_MODE) && READ_DATA_BUS == OUT_RESET)
    else $error("partial reset wrong");
  chk_rst_flags:
    assert property (!run |=> EMPTY_OR_VALID_FLAG == FALL_THROUGH_MODE &&
      FULL_OR_SPACE_FLAG != FALL_THROUGH_MODE)
    else $error("flags wrong after reset");
  chk_replay_std:
    assert property (run && !REPLAY_REQUEST_N && !FALL_THROUGH_MODE |=>
      !EMPTY_OR_VALID_FLAG)
    else $error("replay empty flag");
  chk_replay_ft:
    assert property (run && !REPLAY_REQUEST_N && FALL_THROUGH_MODE |=>
      EMPTY_OR_VALID_FLAG)
    else $error("replay valid flag");
  chk_oe_drive:
    assert property ((!OUTPUT_ENABLE_N)[*2] |-> READ_DATA_OE)
    else $error("bus not driven");
  chk_std_hold:
    assert property (run && READ_ENABLE_N && REPLAY_REQUEST_N &&
      !FALL_THROUGH_MODE |=> $stable(READ_DATA_BUS))
    else $error("bus moved without read");
  chk_hf_cause:
    // Replay rewinds reading, so the held count may jump up too
    assert property ($fell(HALF_FULL_FLAG_N) |->
      !$past(WRITE_ENABLE_N) || !$past(REPLAY_REQUEST_N))
    else $error("half flag without write");
  chk_ft_first:
    assert property (s_ft_write ##1 s_quiet2 |=> !EMPTY_OR_VALID_FLAG)
    else $error("first word late");
endmodule
bind dcf_top dcf_top_asserts u_chk (
  .SYS_CLK, .RSTN, .MASTER_RESET_N, .PARTIAL_RESET_N, .REPLAY_REQUEST_N,
  .MODE_SELECT_SERIAL_IN, .OFFSET_LOAD_STROBE_N, .WRITE_ENABLE_N,
  .READ_ENABLE_N, .OUTPUT_ENABLE_N, .READ_DATA_BUS, .READ_DATA_OE,
  .FULL_OR_SPACE_FLAG, .EMPTY_OR_VALID_FLAG, .ALMOST_FULL_FLAG_N,
  .ALMOST_EMPTY_FLAG_N, .HALF_FULL_FLAG_N, .FALL_THROUGH_MODE
);

// ===== tb/dcf_writer_model.sv
// Writer-side partner pushing runs of counting words
`timescale 1ns/1ps
module dcf_writer_model (
  // Clock
  input  wire logic        clk,
  // Bench control
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [11:0] cnt,
  input  wire logic [17:0] base,
  // Write side
  output logic             wen_n,
  output logic      [17:0] wdata,
  output logic             done
);
  logic        wen_q = 1'b1;
  logic [17:0] wd_q  = 18'h00000;
  logic [11:0] left  = 12'h000;
  logic [17:0] nxt   = 18'h00000;
  ////////////////////////////////////////////////////////////////////////////
  // Slow mode idles between words; a released bus shows the inverse word
  always @(posedge clk) begin
    if (left != 12'h000 && !(slow && !wen_q)) begin
      wen_q <= 1'b0;
      wd_q  <= nxt;
      nxt   <= nxt + 18'h00001;
      left  <= left - 12'h001;
    end else begin
      if (!wen_q) begin
        wd_q <= ~wd_q;
      end
      wen_q <= 1'b1;
      if (start && left == 12'h000) begin
        left <= cnt;
        nxt  <= base;
      end
    end
  end
  assign wen_n = wen_q;
  assign wdata = wd_q;
  assign done  = (left == 12'h000) && wen_q;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the deep buffer top
`timescale 1ns/1ps
module tb;
  import dcf_pkg::*;
  localparam int D  = 2048;
  localparam int AW = $clog2(D);
  localparam logic [2*AW-1:0] SER = {AW'(7), AW'(3)};
  // Fill levels; expected {almost-empty, half, almost-full, full}
  int         tgt[8] = '{126, 127, 1024, 1025, 1921, 1922, 2047, 2048};
  logic [3:0] exf[8] = '{4'h7, 4'hf, 4'hf, 4'hb, 4'hb, 4'h9, 4'h9, 4'h8};
  logic clk, rstn, mrs_n, prs_n, rt_n, si, sen_n, ld_n, ren_n, oe_n;
  logic start, slow, done, wen_n, oe, ff, ef, af_n, ae_n, hf_n, ftm;
  logic [17:0] base, wd, q;
  logic [11:0] cnt;
  int err_total = 0;
  int compares = 0;
  int n;
  dcf_top #(.DEPTH(D), .SDEP(16)) u_dut (
    .SYS_CLK(clk), .RSTN(rstn), .MASTER_RESET_N(mrs_n),
    .PARTIAL_RESET_N(prs_n), .REPLAY_REQUEST_N(rt_n),
    .MODE_SELECT_SERIAL_IN(si), .SERIAL_LOAD_ENABLE_N(sen_n),
    .OFFSET_LOAD_STROBE_N(ld_n), .WRITE_ENABLE_N(wen_n),
    .WRITE_DATA_BUS(wd), .READ_ENABLE_N(ren_n), .OUTPUT_ENABLE_N(oe_n),
    .READ_DATA_BUS(q), .READ_DATA_OE(oe), .FULL_OR_SPACE_FLAG(ff),
    .EMPTY_OR_VALID_FLAG(ef), .ALMOST_FULL_FLAG_N(af_n),
    .ALMOST_EMPTY_FLAG_N(ae_n), .HALF_FULL_FLAG_N(hf_n),
    .FALL_THROUGH_MODE(ftm));
  dcf_writer_model u_wr (.clk(clk), .start(start), .slow(slow),
    .cnt(cnt), .base(base), .wen_n(wen_n), .wdata(wd), .done(done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [17:0] got, logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(int c, int b, logic s);
    int t = 0;
    @(posedge clk);
    cnt   <= 12'(c);
    base  <= 18'(b);
    slow  <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    while (done !== 1'b1 && t < 4000) begin
      tick(1);
      t++;
    end
    chk("wr_done", done, 1'b1);
  endtask
  task automatic rd(logic l, logic [17:0] e, string nm);
    @(posedge clk);
    ren_n <= 1'b0;
    ld_n  <= l;
    @(posedge clk);
    ren_n <= 1'b1;
    ld_n  <= 1'b1;
    #1;
    chk(nm, q, e);
  endtask
  task automatic mrst(logic s, logic l);
    @(posedge clk);
    mrs_n <= 1'b0;
    si    <= s;
    ld_n  <= l;
    @(posedge clk);
    mrs_n <= 1'b1;
    ld_n  <= 1'b1;
    si    <= 1'b0;
    #1;
  endtask
  task automatic prst();
    @(posedge clk);
    prs_n <= 1'b0;
    ld_n  <= 1'b1;
    @(posedge clk);
    prs_n <= 1'b1;
    #1;
  endtask
  task automatic replay();
    @(posedge clk);
    rt_n <= 1'b0;
    @(posedge clk);
    rt_n <= 1'b1;
    #1;
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Longest run is the full fill and drain, about 6300 cycles
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    {rstn, si, start, slow} = 4'h0;
    {mrs_n, prs_n, rt_n, sen_n, ld_n, ren_n, oe_n} = 7'h7f;
    cnt = 12'h000;
    base = 18'h00000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    mrst(1'b0, 1'b0);
    chk("mode", ftm, 1'b0);
    chk("flags", {ff, ef, af_n, ae_n, hf_n}, 5'h15);
    chk("q", q, OUT_RESET);
    @(posedge clk);
    oe_n <= 1'b0;
    tick(2);
    chk("oe", oe, 1'b1);
    rd(1'b0, 18'h0007f, "dflt_e");
    rd(1'b0, 18'h0007f, "dflt_f");
    n = 0;
    foreach (tgt[i]) begin
      wr(tgt[i] - n, n, i == 0);
      n = tgt[i];
      chk("lvl", {ae_n, hf_n, af_n, ff}, exf[i]);
    end
    wr(1, 'h3ffff, 1'b0);
    chk("full", ff, 1'b0);
    for (int i = 0; i < D; i++) rd(1'b1, 18'(i), "data");
    chk("empty", ef, 1'b0);
    rd(1'b1, 18'(D - 1), "hold");
    $display("fill test done");
    @(posedge clk);
    ld_n <= 1'b0;
    wr(1, 5, 1'b0);
    wr(1, 9, 1'b0);
    chk("no_store", ef, 1'b0);
    prst();
    rd(1'b0, 18'h00005, "ofs_e");
    rd(1'b0, 18'h00009, "ofs_f");
    wr(4, 'h100, 1'b0);
    chk("ae4", ae_n, 1'b0);
    wr(1, 'h104, 1'b0);
    chk("ae5", ae_n, 1'b1);
    rd(1'b1, 18'h00100, "d0");
    replay();
    chk("rt_ef", ef, 1'b0);
    wr(1, 'h105, 1'b0);
    for (int i = 0; i < 6; i++) rd(1'b1, 18'(256 + i), "rt");
    $display("standard test done");
    mrst(1'b1, 1'b1);
    chk("ft", {ftm, ff, ef}, 3'h5);
    rd(1'b0, 18'h003ff, "dflt_e");
    rd(1'b0, 18'h003ff, "dflt_f");
    for (int i = 2 * AW - 1; i >= 0; i--) begin
      @(posedge clk);
      sen_n <= 1'b0;
      ld_n  <= 1'b0;
      si    <= SER[i];
    end
    @(posedge clk);
    sen_n <= 1'b1;
    ld_n  <= 1'b1;
    rd(1'b0, 18'h00003, "ser_e");
    rd(1'b0, 18'h00007, "ser_f");
    wr(1, 'h2a5a5, 1'b0);
    tick(1);
    chk("ft1", ef, 1'b1);
    tick(1);
    chk("ft2", ef, 1'b0);
    chk("ftq", q, 18'h2a5a5);
    wr(1, 'h01234, 1'b0);
    replay();
    chk("rt_or", ef, 1'b1);
    tick(1);
    chk("rt_q", q, 18'h2a5a5);
    rd(1'b1, 18'h01234, "ft_rd");
    rd(1'b1, 18'h01234, "ft_last");
    chk("ft_ef", ef, 1'b1);
    prst();
    chk("keep", ftm, 1'b1);
    rd(1'b0, 18'h00003, "keep_e");
    $display("fall-through test done");
    final_report();
  end
endmodule
